// ==== logic/cycle_cost.sv ====
// instruction cycle cost calculator: clocks, read and write bus cycles
// assumes requests come from logic on clock_i; one result per request
//
// Behaviour
// - byte/word moves cost per mode pair
// - long moves cost per mode pair
// - move totals include fetch, reads, writes
// - index size never changes the cost
// - operation times include store and next fetch
// - plus entries add operand location cost fieldwise
// - add/sub costs into register and memory
// - long six-clock add/sub/and/or base becomes eight for register/immediate
// - exclusive or to register needs data register source
// - divide maxima 158 and 140, one read
// - multiply/divide add word-size location cost
// - multiply is 38 plus 2n clocks
// - unsigned multiply n counts one bits
// - signed multiply n counts bit changes
// - bus cycles take four clocks each
// - wait states add to the total
// - clocks, reads, writes; remainder is idle
`timescale 1ns/100ps
`default_nettype none

module cycle_cost
  import cycle_cost_pkg::*;
(
  input wire logic clock_i,       // 100 MHz core clock
  input wire logic rst_n_i,       // asynchronous reset, active low
  input wire logic req_valid_i,   // one-cycle request strobe
  input wire request_t req_i,     // instruction description
  output var logic done_o,        // one-cycle result strobe
  output var result_t result_o    // held until the next result
);

  // ==========================================================
  // multiply data-dependent count
  logic [16:0] ext_src;
  logic [15:0] change_bits;
  logic [4:0] ones_n;
  logic [4:0] change_n;

  // zero below the lsb; each neighbour pair that differs counts
  assign ext_src = {req_i.src_data, 1'b0};
  for (genvar i = 0; i < 16; i++) begin : g_pair
    assign change_bits[i] = ext_src[i+1] ^ ext_src[i];
  end

  // population counts for both multiply flavours
  always_comb begin
    ones_n = 5'h00;
    change_n = 5'h00;
    for (int k = 0; k < 16; k++) begin
      ones_n = ones_n + {4'h0, req_i.src_data[k]};
      change_n = change_n + {4'h0, change_bits[k]};
    end
  end

  // ==========================================================
  // cost selection
  function automatic cost_t add_cost(input cost_t a, input cost_t b);
    add_cost.clocks = a.clocks + b.clocks;
    add_cost.reads = a.reads + b.reads;
    add_cost.writes = a.writes + b.writes;
  endfunction

  function automatic logic is_mem_alt(input mode_t m);
    is_mem_alt = !(m == M_DREG || m == M_AREG || m == M_PC_DISP ||
                   m == M_PC_INDEX || m == M_IMM);
  endfunction

  cost_t ea_src;
  cost_t ea_dst;
  cost_t ea_src_w;
  cost_t base;
  cost_t total;
  logic raise;
  logic illegal;
  logic [CLK_W-1:0] bus_clk;
  logic [CLK_W-1:0] idle;
  logic [4:0] mul_n;

  // index modes carry one figure only, whatever the index size
  always_comb begin
    ea_src = req_i.size_long ? EA_L[req_i.src_mode] :
                               EA_BW[req_i.src_mode];
    ea_dst = req_i.size_long ? EA_L[req_i.dst_mode] :
                               EA_BW[req_i.dst_mode];
    ea_src_w = EA_BW[req_i.src_mode];
  end

  // base cost by class, plus the location cost where it applies
  always_comb begin
    base = C_NONE;
    illegal = 1'b0;
    raise = 1'b0;
    mul_n = (req_i.op == OP_SIGNED_MULTIPLY) ? change_n : ones_n;
    case (req_i.op)
      OP_MOVE: begin
        // fetch plus source location cost plus destination table reads and writes
        base = add_cost(C_MOVE, ea_src);
        base = add_cost(base, req_i.size_long ?
                        MV_DST_L[req_i.dst_mode] :
                        MV_DST_BW[req_i.dst_mode]);
        // long pc-relative to absolute long stands at five reads
        if (req_i.size_long && req_i.src_mode == M_PC_DISP &&
            req_i.dst_mode == M_ABS_L) begin
          base.reads = base.reads - 4'h1;
        end
        illegal = (req_i.dst_mode == M_PC_DISP) ||
                  (req_i.dst_mode == M_PC_INDEX) ||
                  (req_i.dst_mode == M_IMM);
      end
      OP_ADD, OP_SUB, OP_AND, OP_OR: begin
        case (req_i.target)
          TO_ADDRESS_REG: begin
            base = add_cost(req_i.size_long ? C_OP_L : C_AREG_BW,
                            ea_src);
            raise = req_i.size_long;
            // add/sub word form is legal and shares its size code with byte; and/or flagged
            illegal = req_i.op == OP_AND || req_i.op == OP_OR;
          end
          TO_DATA_REG: begin
            base = add_cost(req_i.size_long ? C_OP_L : C_OP_BW,
                            ea_src);
            raise = req_i.size_long;
          end
          TO_MEMORY: begin
            base = add_cost(req_i.size_long ? C_MEM_L : C_MEM_BW,
                            ea_dst);
            illegal = !is_mem_alt(req_i.dst_mode);
          end
          default: illegal = 1'b1;
        endcase
      end
      OP_CMP: begin
        case (req_i.target)
          TO_ADDRESS_REG: begin
            base = add_cost(C_COMPARE_ADDRESS_REG, ea_src);
            // byte and word share one size code, so never flagged
          end
          TO_DATA_REG: begin
            base = add_cost(req_i.size_long ? C_OP_L : C_OP_BW,
                            ea_src);
          end
          default: illegal = 1'b1;
        endcase
      end
      OP_EXCLUSIVE_OR: begin
        case (req_i.target)
          TO_DATA_REG: begin
            // only a data register source; no location cost
            base = req_i.size_long ? C_EOR_L : C_OP_BW;
            illegal = (req_i.src_mode != M_DREG);
          end
          TO_MEMORY: begin
            base = add_cost(req_i.size_long ? C_MEM_L : C_MEM_BW,
                            ea_dst);
            illegal = !is_mem_alt(req_i.dst_mode);
          end
          default: illegal = 1'b1;
        endcase
      end
      OP_UNSIGNED_MULTIPLY, OP_SIGNED_MULTIPLY: begin
        base = C_MUL_RD;
        base.clocks = MUL_BASE_CLK + {4'h0, mul_n, 1'b0};
        base = add_cost(base, ea_src_w);
        illegal = (req_i.target != TO_DATA_REG) ||
                  (req_i.src_mode == M_AREG);
      end
      OP_UNSIGNED_DIVIDE: begin
        base = add_cost(C_UNSIGNED_DIVIDE, ea_src_w);
        illegal = (req_i.target != TO_DATA_REG) ||
                  (req_i.src_mode == M_AREG);
      end
      OP_SIGNED_DIVIDE: begin
        base = add_cost(C_SIGNED_DIVIDE, ea_src_w);
        illegal = (req_i.target != TO_DATA_REG) ||
                  (req_i.src_mode == M_AREG);
      end
      default: illegal = 1'b1;
    endcase
  end

  // six-clock long add/sub/and/or base grows by two for register or immediate source
  always_comb begin
    total = base;
    if (raise && (req_i.src_mode == M_DREG ||
                  req_i.src_mode == M_AREG ||
                  req_i.src_mode == M_IMM)) begin
      total.clocks = base.clocks + RAISE_CLK;
    end
    total.clocks = total.clocks + {2'b00, req_i.waits};
  end

  // idle remainder: neither a bus cycle nor a wait state
  always_comb begin
    bus_clk = CLK_W'(BUS_CYCLE_CLK * (32'(total.reads) +
                                      32'(total.writes)));
    idle = total.clocks - {2'b00, req_i.waits} - bus_clk;
  end

  // ==========================================================
  // result registers
  logic done_r;
  logic done_nxt;
  result_t result_r;
  result_t result_nxt;

  // result stands until the next request replaces it
  always_comb begin
    done_nxt = req_valid_i;
    result_nxt = result_r;
    if (req_valid_i) begin
      result_nxt.cost = total;
      result_nxt.idle = idle;
      result_nxt.illegal = illegal;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_r <= 1'b0;
      result_r <= '0;
    end else begin
      done_r <= done_nxt;
      result_r <= result_nxt;
    end
  end

  assign done_o = done_r;
  assign result_o = result_r;

  // ==========================================================
  // checks
  sequence s_req_move(logic l, mode_t s, mode_t d);
    req_valid_i && req_i.op == OP_MOVE && req_i.size_long == l &&
    req_i.src_mode == s && req_i.dst_mode == d && req_i.waits == 8'h00;
  endsequence

  sequence s_req_std(op_class_t o, logic l, target_t t, mode_t s);
    req_valid_i && req_i.op == o && req_i.size_long == l &&
    req_i.target == t && req_i.src_mode == s && req_i.waits == 8'h00;
  endsequence

  property p_move_reg;
    @(posedge clock_i) disable iff (!rst_n_i)
    s_req_move(1'b0, M_DREG, M_DREG) |=> done_o &&
      result_o.cost == cost_t'{10'h004, 4'h1, 3'h0};
  endproperty
  a_move_reg: assert property (p_move_reg)
    else $error("register move not 4(1/0)");

  property p_move_abs;
    @(posedge clock_i) disable iff (!rst_n_i)
    s_req_move(1'b0, M_ABS_L, M_ABS_L) |=>
      result_o.cost == cost_t'{10'h01c, 4'h6, 3'h1} && result_o.idle == 10'h0;
  endproperty
  a_move_abs: assert property (p_move_abs)
    else $error("absolute long move not 28(6/1)");

  property p_move_long;
    @(posedge clock_i) disable iff (!rst_n_i)
    s_req_move(1'b1, M_DREG, M_IND) |=>
      result_o.cost == cost_t'{10'h00c, 4'h1, 3'h2};
  endproperty
  a_move_long: assert property (p_move_long)
    else $error("long move to indirect not 12(1/2)");

  property p_add_mem;
    @(posedge clock_i) disable iff (!rst_n_i)
    req_valid_i && req_i.op == OP_ADD && !req_i.size_long &&
    req_i.target == TO_MEMORY && req_i.dst_mode == M_ABS_L &&
    req_i.waits == 8'h00 |=>
      result_o.cost == cost_t'{10'h014, 4'h4, 3'h1};
  endproperty
  a_add_mem: assert property (p_add_mem)
    else $error("add to memory location cost wrong");

  property p_raise;
    @(posedge clock_i) disable iff (!rst_n_i)
    s_req_std(OP_SUB, 1'b1, TO_DATA_REG, M_DREG) |=>
      result_o.cost.clocks == 10'h008;
  endproperty
  a_raise: assert property (p_raise)
    else $error("long register source base not raised to eight");

  property p_eor;
    @(posedge clock_i) disable iff (!rst_n_i)
    s_req_std(OP_EXCLUSIVE_OR, 1'b1, TO_DATA_REG, M_DREG) |=>
      result_o.cost == cost_t'{10'h008, 4'h1, 3'h0} && !result_o.illegal;
  endproperty
  a_eor: assert property (p_eor)
    else $error("exclusive or long to register not 8(1/0)");

  property p_signed_divide;
    @(posedge clock_i) disable iff (!rst_n_i)
    s_req_std(OP_SIGNED_DIVIDE, 1'b1, TO_DATA_REG, M_IND) |=>
      result_o.cost == cost_t'{10'h0a2, 4'h2, 3'h0};
  endproperty
  a_signed_divide: assert property (p_signed_divide)
    else $error("signed divide not 158 plus word location cost");

  property p_signed_multiply_worst;
    @(posedge clock_i) disable iff (!rst_n_i)
    s_req_std(OP_SIGNED_MULTIPLY, 1'b0, TO_DATA_REG, M_DREG) ##0
    req_i.src_data == 16'h5555 |=> result_o.cost.clocks == 10'h046;
  endproperty
  a_signed_multiply_worst: assert property (p_signed_multiply_worst)
    else $error("signed multiply worst case not 70");

  property p_unsigned_multiply;
    @(posedge clock_i) disable iff (!rst_n_i)
    s_req_std(OP_UNSIGNED_MULTIPLY, 1'b0, TO_DATA_REG, M_DREG) |=>
      result_o.cost.clocks == MUL_BASE_CLK +
        10'(2 * $countones($past(req_i.src_data)));
  endproperty
  a_unsigned_multiply: assert property (p_unsigned_multiply)
    else $error("unsigned multiply count wrong");

  property p_wait;
    @(posedge clock_i) disable iff (!rst_n_i)
    req_valid_i ##1 done_o |-> result_o.cost.clocks ==
      result_o.idle + 10'(BUS_CYCLE_CLK) *
      (10'(result_o.cost.reads) + 10'(result_o.cost.writes)) +
      {2'b00, $past(req_i.waits)};
  endproperty
  a_wait: assert property (p_wait)
    else $error("clock total does not split into bus, wait, idle");

  property p_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
    !req_valid_i |=> !done_o && $stable(result_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("result changed without a request");

endmodule : cycle_cost

`default_nettype wire

// ==== logic/cycle_cost_pkg.sv ====
// constants, codes and carriers for the instruction cycle cost calculator
// assumes a single clock; clock figures count processor clock periods, reads and writes count bus cycles
package cycle_cost_pkg;

  // ==========================================================
  // operand location modes, operation classes, result targets
  typedef enum logic [3:0] {
    M_DREG, M_AREG, M_IND, M_POSTINC, M_PREDEC, M_DISP,
    M_INDEX, M_ABS_W, M_ABS_L, M_PC_DISP, M_PC_INDEX, M_IMM
  } mode_t;

  typedef enum logic [3:0] {
    OP_MOVE, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_CMP, OP_EXCLUSIVE_OR,
    OP_UNSIGNED_MULTIPLY, OP_SIGNED_MULTIPLY,
    OP_UNSIGNED_DIVIDE, OP_SIGNED_DIVIDE
  } op_class_t;

  // where a standard operation leaves its result
  typedef enum logic [1:0] {
    TO_ADDRESS_REG, TO_DATA_REG, TO_MEMORY
  } target_t;

  // ==========================================================
  // carriers
  localparam int CLK_W = 10;
  localparam int RD_W = 4;
  localparam int WR_W = 3;
  localparam int WAIT_W = 8;

  typedef struct packed {
    logic [CLK_W-1:0] clocks;
    logic [RD_W-1:0] reads;
    logic [WR_W-1:0] writes;
  } cost_t;

  typedef struct packed {
    op_class_t op;
    logic size_long;          // 1: long, 0: byte or word
    target_t target;          // standard operations only
    mode_t src_mode;
    mode_t dst_mode;          // moves, and memory target of standard ops
    logic [15:0] src_data;    // multiply source operand
    logic [WAIT_W-1:0] waits; // wait states of the memory accesses
  } request_t;

  typedef struct packed {
    cost_t cost;
    logic [CLK_W-1:0] idle;   // clocks with the bus idle
    logic illegal;            // combination has no defined timing
  } result_t;

  // ==========================================================
  // timing figures
  localparam int BUS_CYCLE_CLK = 4;
  localparam logic [CLK_W-1:0] BUS_CLK = 10'h004;
  localparam logic [CLK_W-1:0] RAISE_CLK = 10'h002;
  localparam logic [CLK_W-1:0] MUL_BASE_CLK = 10'h026;
  localparam cost_t C_NONE = '{10'h000, 4'h0, 3'h0};
  localparam cost_t C_MOVE = '{10'h004, 4'h1, 3'h0};
  localparam cost_t C_OP_BW = '{10'h004, 4'h1, 3'h0};
  localparam cost_t C_OP_L = '{10'h006, 4'h1, 3'h0};
  localparam cost_t C_AREG_BW = '{10'h008, 4'h1, 3'h0};
  localparam cost_t C_COMPARE_ADDRESS_REG = '{10'h006, 4'h1, 3'h0};
  localparam cost_t C_MEM_BW = '{10'h008, 4'h1, 3'h1};
  localparam cost_t C_MEM_L = '{10'h00c, 4'h1, 3'h2};
  localparam cost_t C_EOR_L = '{10'h008, 4'h1, 3'h0};
  localparam cost_t C_SIGNED_DIVIDE = '{10'h09e, 4'h1, 3'h0};
  localparam cost_t C_UNSIGNED_DIVIDE = '{10'h08c, 4'h1, 3'h0};
  localparam cost_t C_MUL_RD = '{10'h000, 4'h1, 3'h0};

  // operand location cost, indexed by mode_t
  localparam cost_t EA_BW [12] = '{
    '{10'h000, 4'h0, 3'h0}, '{10'h000, 4'h0, 3'h0},
    '{10'h004, 4'h1, 3'h0}, '{10'h004, 4'h1, 3'h0},
    '{10'h006, 4'h1, 3'h0}, '{10'h008, 4'h2, 3'h0},
    '{10'h00a, 4'h2, 3'h0}, '{10'h008, 4'h2, 3'h0},
    '{10'h00c, 4'h3, 3'h0}, '{10'h008, 4'h2, 3'h0},
    '{10'h00a, 4'h2, 3'h0}, '{10'h004, 4'h1, 3'h0}};
  localparam cost_t EA_L [12] = '{
    '{10'h000, 4'h0, 3'h0}, '{10'h000, 4'h0, 3'h0},
    '{10'h008, 4'h2, 3'h0}, '{10'h008, 4'h2, 3'h0},
    '{10'h00a, 4'h2, 3'h0}, '{10'h00c, 4'h3, 3'h0},
    '{10'h00e, 4'h3, 3'h0}, '{10'h00c, 4'h3, 3'h0},
    '{10'h010, 4'h4, 3'h0}, '{10'h00c, 4'h3, 3'h0},
    '{10'h00e, 4'h3, 3'h0}, '{10'h008, 4'h2, 3'h0}};

  // move destination cost, indexed by mode_t (pc and immediate unused)
  localparam cost_t MV_DST_BW [12] = '{
    '{10'h000, 4'h0, 3'h0}, '{10'h000, 4'h0, 3'h0},
    '{10'h004, 4'h0, 3'h1}, '{10'h004, 4'h0, 3'h1},
    '{10'h004, 4'h0, 3'h1}, '{10'h008, 4'h1, 3'h1},
    '{10'h00a, 4'h1, 3'h1}, '{10'h008, 4'h1, 3'h1},
    '{10'h00c, 4'h2, 3'h1}, '{10'h000, 4'h0, 3'h0},
    '{10'h000, 4'h0, 3'h0}, '{10'h000, 4'h0, 3'h0}};
  localparam cost_t MV_DST_L [12] = '{
    '{10'h000, 4'h0, 3'h0}, '{10'h000, 4'h0, 3'h0},
    '{10'h008, 4'h0, 3'h2}, '{10'h008, 4'h0, 3'h2},
    '{10'h008, 4'h0, 3'h2}, '{10'h00c, 4'h1, 3'h2},
    '{10'h00e, 4'h1, 3'h2}, '{10'h00c, 4'h1, 3'h2},
    '{10'h010, 4'h2, 3'h2}, '{10'h000, 4'h0, 3'h0},
    '{10'h000, 4'h0, 3'h0}, '{10'h000, 4'h0, 3'h0}};

endpackage : cycle_cost_pkg

// ==== test/mem_access_model.sv ====
// far-side memory model: turns slow access lengths into wait-state clocks
// assumes every access of one instruction has the same length
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// memory timing of the system bus
module mem_access_model
  import cycle_cost_pkg::*;
(
  input wire logic [3:0] accesses_i,   // read plus write bus cycles
  input wire logic [7:0] cycle_clk_i,  // clocks each access really takes
  output logic [WAIT_W-1:0] waits_o    // extra clocks over nominal
);
  // a nominal access is four clocks; only the excess stretches the total
  always_comb begin
    if (cycle_clk_i > 8'(BUS_CYCLE_CLK)) begin
      waits_o = WAIT_W'(accesses_i * (cycle_clk_i - 8'(BUS_CYCLE_CLK)));
    end else begin
      waits_o = '0;
    end
  end
endmodule // mem_access_model

`default_nettype wire

// ==== test/tb_instruction_cycle_timing.sv ====
// self-checking bench for the cycle cost calculator
// assumes one result per request, registered at the taking edge
`timescale 1ns/100ps
`default_nettype none

`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
  mismatches++; $display("ERROR %0t: got %0h expected %0h", $time, got, \
  exp); end end

module tb_instruction_cycle_timing;
  import cycle_cost_pkg::*;

  // ==========================================================
  // signals and instances
  logic clock_i;
  logic rst_n_i;
  logic req_valid;
  request_t req;
  logic done_o;
  result_t result_o;
  logic [3:0] acc;
  logic [7:0] acc_clk;
  logic [WAIT_W-1:0] mem_waits;
  int mismatches;
  int total_checks;

  cycle_cost i_dut (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .req_valid_i(req_valid),
    .req_i(req),
    .done_o(done_o),
    .result_o(result_o)
  );

  mem_access_model i_mem (
    .accesses_i(acc),
    .cycle_clk_i(acc_clk),
    .waits_o(mem_waits)
  );

  // 100 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // ==========================================================
  // shared tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // request launched just after an edge, taken at the next one
  task automatic issue(input op_class_t op, input logic sz,
      input target_t tg, input mode_t s, input mode_t d,
      input logic [15:0] dat, input logic [7:0] w);
    @(posedge clock_i);
    req_valid <= 1'b1;
    req <= '{op: op, size_long: sz, target: tg, src_mode: s,
             dst_mode: d, src_data: dat, waits: w};
  endtask

  // idle is what the bus cycles and waits leave of the total
  task automatic expect_cost(input logic [9:0] c, input logic [3:0] r,
      input logic [2:0] wr, input logic [7:0] w, input logic ill);
    logic [9:0] id;
    id = c - 10'(w) - 10'(4 * (r + wr));
    `CHECK(result_o.cost.clocks, c)
    `CHECK(result_o.cost.reads, r)
    `CHECK(result_o.cost.writes, wr)
    `CHECK(result_o.idle, id)
    `CHECK(result_o.illegal, ill)
  endtask

  task automatic run(input op_class_t op, input logic sz, input target_t tg,
      input mode_t s, input mode_t d, input logic [15:0] dat,
      input logic [7:0] w, input logic [9:0] c, input logic [3:0] r,
      input logic [2:0] wr, input logic ill);
    int n;
    issue(op, sz, tg, s, d, dat, w);
    @(posedge clock_i);
    req_valid <= 1'b0;
    n = 0;
    #1;
    // bounded wait for the result strobe
    while (done_o !== 1'b1 && n < 4) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    if (n == 4) begin
      $display("ERROR %0t: no result strobe", $time);
      mismatches++;
      summarize();
    end
    expect_cost(c, r, wr, w, ill);
  endtask

  // ==========================================================
  // scenarios
  task automatic moves_bw();
    run(OP_MOVE, 0, TO_DATA_REG, M_DREG, M_DREG, 0, 0, 4, 1, 0, 0);
    run(OP_MOVE, 0, TO_DATA_REG, M_ABS_L, M_ABS_L, 0, 0, 28, 6, 1, 0);
    run(OP_MOVE, 0, TO_DATA_REG, M_IND, M_IND, 0, 0, 12, 2, 1, 0);
    run(OP_MOVE, 0, TO_DATA_REG, M_IMM, M_ABS_L, 0, 0, 20, 4, 1, 0);
    run(OP_MOVE, 0, TO_DATA_REG, M_PREDEC, M_AREG, 0, 0, 10, 2, 0, 0);
    run(OP_MOVE, 0, TO_DATA_REG, M_DISP, M_ABS_W, 0, 0, 20, 4, 1, 0);
  endtask

  task automatic moves_long();
    run(OP_MOVE, 1, TO_DATA_REG, M_DREG, M_IND, 0, 0, 12, 1, 2, 0);
    run(OP_MOVE, 1, TO_DATA_REG, M_ABS_L, M_ABS_L, 0, 0, 36, 7, 2, 0);
    run(OP_MOVE, 1, TO_DATA_REG, M_PC_DISP, M_ABS_L, 0, 0, 32, 5, 2, 0);
    run(OP_MOVE, 1, TO_DATA_REG, M_PREDEC, M_INDEX, 0, 0, 28, 4, 2, 0);
    run(OP_MOVE, 1, TO_DATA_REG, M_POSTINC, M_DISP, 0, 0, 24, 4, 2, 0);
  endtask

  // both indexed modes cost alike whatever the index width
  task automatic indexed();
    run(OP_MOVE, 0, TO_DATA_REG, M_INDEX, M_DREG, 0, 0, 14, 3, 0, 0);
    run(OP_MOVE, 0, TO_DATA_REG, M_PC_INDEX, M_INDEX, 0, 0, 24, 4, 1, 0);
  endtask

  task automatic add_sub();
    run(OP_ADD, 0, TO_DATA_REG, M_IND, M_DREG, 0, 0, 8, 2, 0, 0);
    run(OP_SUB, 0, TO_MEMORY, M_DREG, M_IND, 0, 0, 12, 2, 1, 0);
    run(OP_ADD, 1, TO_MEMORY, M_DREG, M_IND, 0, 0, 20, 3, 2, 0);
    run(OP_ADD, 0, TO_ADDRESS_REG, M_DREG, M_DREG, 0, 0, 8, 1, 0, 0);
    run(OP_AND, 0, TO_MEMORY, M_DREG, M_ABS_L, 0, 0, 20, 4, 1, 0);
    run(OP_ADD, 0, TO_MEMORY, M_DREG, M_ABS_L, 0, 0, 20, 4, 1, 0);
    run(OP_CMP, 0, TO_ADDRESS_REG, M_DISP, M_DREG, 0, 0, 14, 3, 0, 0);
  endtask

  // long six-clock add/sub/and/or base raised only for register or immediate source
  task automatic long_raise();
    run(OP_ADD, 1, TO_DATA_REG, M_DREG, M_DREG, 0, 0, 8, 1, 0, 0);
    run(OP_SUB, 1, TO_DATA_REG, M_IMM, M_DREG, 0, 0, 16, 3, 0, 0);
    run(OP_OR, 1, TO_DATA_REG, M_IND, M_DREG, 0, 0, 14, 3, 0, 0);
    run(OP_AND, 1, TO_DATA_REG, M_AREG, M_DREG, 0, 0, 8, 1, 0, 0);
    run(OP_CMP, 1, TO_DATA_REG, M_DREG, M_DREG, 0, 0, 6, 1, 0, 0);
    run(OP_SUB, 1, TO_DATA_REG, M_DREG, M_DREG, 0, 0, 8, 1, 0, 0);
    run(OP_ADD, 1, TO_ADDRESS_REG, M_AREG, M_DREG, 0, 0, 8, 1, 0, 0);
  endtask

  task automatic exclusive_or();
    run(OP_EXCLUSIVE_OR, 0, TO_DATA_REG, M_DREG, M_DREG, 0, 0, 4, 1, 0,
        0);
    run(OP_EXCLUSIVE_OR, 1, TO_DATA_REG, M_DREG, M_DREG, 0, 0, 8, 1, 0,
        0);
    issue(OP_EXCLUSIVE_OR, 0, TO_DATA_REG, M_IND, M_DREG, 0, 0);
    @(posedge clock_i);
    req_valid <= 1'b0;
    #1;
    `CHECK(result_o.illegal, 1'b1)
    run(OP_EXCLUSIVE_OR, 1, TO_MEMORY, M_DREG, M_POSTINC, 0, 0, 20, 3, 2,
        0);
  endtask

  // undefined combinations back to back, a legal move second, each flag checked one after another
  task automatic refused_combos();
    issue(OP_MOVE, 0, TO_DATA_REG, M_DREG, M_IMM, 0, 0);
    issue(OP_MOVE, 0, TO_DATA_REG, M_DREG, M_DREG, 0, 0);
    #1;
    `CHECK(result_o.illegal, 1'b1)
    issue(OP_SUB, 0, TO_MEMORY, M_DREG, M_PC_DISP, 0, 0);
    #1;
    `CHECK(result_o.illegal, 1'b0)
    issue(OP_UNSIGNED_MULTIPLY, 0, TO_DATA_REG, M_AREG, M_DREG, 0, 0);
    #1;
    `CHECK(result_o.illegal, 1'b1)
    @(posedge clock_i);
    req_valid <= 1'b0;
    #1;
    `CHECK(result_o.illegal, 1'b1)
  endtask

  task automatic mul_div();
    run(OP_SIGNED_DIVIDE, 0, TO_DATA_REG, M_DREG, M_DREG, 0, 0, 158, 1, 0,
        0);
    run(OP_UNSIGNED_DIVIDE, 1, TO_DATA_REG, M_IND, M_DREG, 0, 0, 144, 2, 0,
        0);
    run(OP_SIGNED_DIVIDE, 1, TO_DATA_REG, M_IND, M_DREG, 0, 0, 162, 2, 0,
        0);
    run(OP_UNSIGNED_MULTIPLY, 0, TO_DATA_REG, M_DREG, M_DREG, 16'h0000, 0,
        38, 1, 0, 0);
    run(OP_UNSIGNED_MULTIPLY, 0, TO_DATA_REG, M_DREG, M_DREG, 16'hffff, 0,
        70, 1, 0, 0);
    run(OP_SIGNED_MULTIPLY, 0, TO_DATA_REG, M_DREG, M_DREG, 16'h5555, 0,
        70, 1, 0, 0);
    run(OP_SIGNED_MULTIPLY, 0, TO_DATA_REG, M_DREG, M_DREG, 16'hffff, 0,
        40, 1, 0, 0);
    run(OP_UNSIGNED_MULTIPLY, 1, TO_DATA_REG, M_IND, M_DREG, 16'h00ff, 0,
        58, 2, 0, 0);
  endtask

  // slow memory stretches each access; the excess lands in the total
  task automatic slow_memory();
    acc = 4'h1;
    acc_clk = 8'h07;
    #1;
    run(OP_MOVE, 0, TO_DATA_REG, M_DREG, M_DREG, 0, mem_waits, 7, 1, 0,
        0);
    acc = 4'h9;
    acc_clk = 8'h06;
    #1;
    run(OP_MOVE, 1, TO_DATA_REG, M_ABS_L, M_ABS_L, 0, mem_waits, 54, 7, 2,
        0);
  endtask

  // two requests on consecutive edges, then reset in mid-run
  task automatic back_to_back();
    issue(OP_MOVE, 0, TO_DATA_REG, M_DREG, M_IND, 0, 0);
    issue(OP_MOVE, 1, TO_DATA_REG, M_IND, M_DREG, 0, 0);
    #1;
    expect_cost(8, 1, 1, 0, 0);
    @(posedge clock_i);
    req_valid <= 1'b0;
    #1;
    expect_cost(12, 3, 0, 0, 0);
    @(posedge clock_i);
    #1;
    `CHECK(done_o, 1'b0)
    expect_cost(12, 3, 0, 0, 0);
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    #1;
    `CHECK(done_o, 1'b0)
    `CHECK(result_o, result_t'(0))
    @(posedge clock_i);
    rst_n_i <= 1'b1;
    run(OP_MOVE, 0, TO_DATA_REG, M_DREG, M_DREG, 0, 0, 4, 1, 0, 0);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    mismatches = 0;
    total_checks = 0;
    rst_n_i = 1'b0;
    req_valid = 1'b0;
    req = '0;
    acc = 4'h0;
    acc_clk = 8'h04;
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    moves_bw();
    moves_long();
    indexed();
    add_sub();
    long_raise();
    exclusive_or();
    refused_combos();
    mul_div();
    slow_memory();
    back_to_back();
    summarize();
  end

  // cuts a hang short at 100 us, well beyond the length of a normal run
  initial begin
    #100000;
    mismatches++;
    summarize();
  end
endmodule // tb_instruction_cycle_timing

`default_nettype wire
